// ===== rtl/udcl_i2c_byte.sv
`timescale 1ns/1ps
// ======================================================================
// i2c byte engine: start, stop, write byte, read byte
// ======================================================================
module udcl_i2c_byte (
   input  wire logic               clk_i,
   input  wire logic               rst_b_i,
   input  wire logic               go_i,
   input  wire udcl_pkg::udcl_cmd_t cmd_i,
   input  wire logic [7:0]         wdata_i,
   input  wire logic               rd_last_i,
   output logic                    done_o,
   output logic                    nack_o,
   output logic [7:0]              rdata_o,
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   output logic                    scl_oe_o,
   output logic                    sda_oe_o
);

   logic [udcl_pkg::DIV_W-1:0] div;
   logic                       tick;
   logic                       busy;
   udcl_pkg::udcl_cmd_t        cmd;
   logic [3:0]                 bitn;
   logic [1:0]                 ph;
   logic [8:0]                 sh;

   // ==================================================================
   // quarter-bit enable pulse
   // ==================================================================
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div <= '0;
      end else if (!busy || tick) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end
   assign tick = busy && (div == udcl_pkg::DIV_W'(udcl_pkg::SCL_HALF_CYC / 2 - 1));

   // ==================================================================
   // sequencer: four phases per bit, open-drain lines
   // ==================================================================
   // scl is low in phases 0 and 3; a clock-stretching slave is not waited on
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy     <= 1'b0;
         cmd      <= udcl_pkg::UDCL_CMD_START;
         bitn     <= '0;
         ph       <= '0;
         sh       <= '0;
         done_o   <= 1'b0;
         nack_o   <= 1'b0;
         rdata_o  <= '0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (!busy) begin
            if (go_i) begin
               busy <= 1'b1;
               cmd  <= cmd_i;
               bitn <= '0;
               ph   <= '0;
               // write: 8 data bits then release for ack; read: release then ack/nack
               sh   <= (cmd_i == udcl_pkg::UDCL_CMD_READ) ? {8'hFF, rd_last_i}
                                                          : {wdata_i, 1'b1};
            end
         end else if (tick) begin
            ph <= ph + 1'b1;
            unique case (cmd)
               udcl_pkg::UDCL_CMD_START: begin
                  // sda falls while scl high, then scl pulled low
                  unique case (ph)
                     2'd0: begin sda_oe_o <= 1'b0; scl_oe_o <= 1'b0; end
                     2'd1: sda_oe_o <= 1'b1;
                     2'd2: scl_oe_o <= 1'b1;
                     2'd3: begin busy <= 1'b0; done_o <= 1'b1; end
                  endcase
               end
               udcl_pkg::UDCL_CMD_STOP: begin
                  unique case (ph)
                     2'd0: sda_oe_o <= 1'b1;
                     2'd1: scl_oe_o <= 1'b0;
                     2'd2: sda_oe_o <= 1'b0;
                     2'd3: begin busy <= 1'b0; done_o <= 1'b1; end
                  endcase
               end
               default: begin
                  unique case (ph)
                     2'd0: sda_oe_o <= ~sh[8];
                     2'd1: scl_oe_o <= 1'b0;
                     2'd2: begin
                        if (bitn == 4'd8) begin
                           nack_o <= (cmd == udcl_pkg::UDCL_CMD_WRITE) ? sda_i : 1'b0;
                        end else begin
                           rdata_o <= {rdata_o[6:0], sda_i};
                        end
                     end
                     2'd3: begin
                        scl_oe_o <= 1'b1;
                        sh       <= {sh[7:0], 1'b1};
                        bitn     <= bitn + 1'b1;
                        if (bitn == 4'd8) begin
                           busy   <= 1'b0;
                           done_o <= 1'b1;
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end

   // scl input is not used for arbitration in this single-master loader
   logic unused_scl;
   assign unused_scl = scl_i;

endmodule // udcl_i2c_byte

// ===== rtl/udcl_loader.sv
`timescale 1ns/1ps
//
// Contract
// - sample both i2c line levels once after reset as straps
// - no eeprom: sda low means wakeup; scl high means self-powered
// - probe the eeprom only when both straps are high
// - probing reads eeprom locations zero to seven
// - contents valid only when location seven equals the signature
// - vendor id: location zero low byte, location one high byte
// - product id: location two low byte, location three high byte
// - attributes byte taken from location four when valid
// - attributes: bit7 one, bit6 self-powered, bit5 wakeup, rest zero
// - default attributes byte is 0xA0
// - max power taken from location five, units of 2 mA
// - default max power reports 94 mA
// - product id default unless eeprom valid
// - vendor id default unless eeprom valid
//
module udcl_loader (
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output logic                     scl_oe_o,
   output logic                     sda_oe_o,
   output udcl_pkg::udcl_desc_t     desc_o,
   output logic                     ready_o,
   output logic                     ee_valid_o
);

   typedef enum logic [3:0] {
      ST_STRAP  = 4'b0000,
      ST_DECIDE = 4'b0001,
      ST_START1 = 4'b0010,
      ST_DEVW   = 4'b0011,
      ST_ADDR   = 4'b0100,
      ST_START2 = 4'b0101,
      ST_DEVR   = 4'b0110,
      ST_READ   = 4'b0111,
      ST_STOP   = 4'b1000,
      ST_APPLY  = 4'b1001,
      ST_DONE   = 4'b1010
   } udcl_state_t;

   logic                rst_s1;
   logic                rst_b;
   udcl_state_t         state;
   logic                strap_sda;
   logic                strap_scl;
   logic                failed;
   logic [7:0]          mem [udcl_pkg::EE_NBYTES];
   logic [2:0]          idx;
   logic                go;
   logic                waiting;
   udcl_pkg::udcl_cmd_t cmd;
   logic [7:0]          wdata;
   logic                bdone;
   logic                bnack;
   logic [7:0]          bdata;
   logic                b_scl_oe;
   logic                b_sda_oe;

   // ==================================================================
   // reset release
   // ==================================================================
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1 <= 1'b0;
         rst_b  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_b  <= rst_s1;
      end
   end

   // ==================================================================
   // attributes helper: fixed one in bit 7, reserved bits cleared
   // ==================================================================
   function automatic logic [7:0] make_attr(input logic self_pwr, input logic wake);
      logic [7:0] a;
      a = '0;
      a[udcl_pkg::ATTR_ONE_BIT]  = 1'b1;
      a[udcl_pkg::ATTR_SELF_BIT] = self_pwr;
      a[udcl_pkg::ATTR_WAKE_BIT] = wake;
      return a;
   endfunction

   // ==================================================================
   // byte engine
   // ==================================================================
   udcl_i2c_byte u_byte (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b),
      .go_i      (go),
      .cmd_i     (cmd),
      .wdata_i   (wdata),
      .rd_last_i (idx == 3'(udcl_pkg::EE_NBYTES - 1)),
      .done_o    (bdone),
      .nack_o    (bnack),
      .rdata_o   (bdata),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .scl_oe_o  (b_scl_oe),
      .sda_oe_o  (b_sda_oe)
   );

   // ==================================================================
   // command for each state
   // ==================================================================
   always_comb begin
      cmd   = udcl_pkg::UDCL_CMD_START;
      wdata = '0;
      unique case (state)
         ST_START1, ST_START2: cmd = udcl_pkg::UDCL_CMD_START;
         ST_DEVW: begin cmd = udcl_pkg::UDCL_CMD_WRITE; wdata = udcl_pkg::EE_DEV_WR; end
         ST_ADDR: begin cmd = udcl_pkg::UDCL_CMD_WRITE; wdata = 8'h00; end
         ST_DEVR: begin cmd = udcl_pkg::UDCL_CMD_WRITE; wdata = udcl_pkg::EE_DEV_RD; end
         ST_READ: cmd = udcl_pkg::UDCL_CMD_READ;
         ST_STOP: cmd = udcl_pkg::UDCL_CMD_STOP;
         default: cmd = udcl_pkg::UDCL_CMD_START;
      endcase
   end

   // ==================================================================
   // sequencer
   // ==================================================================
   // a bus step is launched once, then the state waits for its done pulse
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         state     <= ST_STRAP;
         strap_sda <= 1'b0;
         strap_scl <= 1'b0;
         failed    <= 1'b0;
         idx       <= '0;
         go        <= 1'b0;
         waiting   <= 1'b0;
      end else begin
         go <= 1'b0;
         unique case (state)
            ST_STRAP: begin
               strap_sda <= sda_i;
               strap_scl <= scl_i;
               state     <= ST_DECIDE;
            end
            ST_DECIDE: begin
               // probe only with both straps high
               state <= (strap_sda && strap_scl) ? ST_START1 : ST_APPLY;
            end
            ST_APPLY, ST_DONE: begin
               state <= ST_DONE;
            end
            default: begin
               if (!waiting) begin
                  go      <= 1'b1;
                  waiting <= 1'b1;
               end else if (bdone) begin
                  waiting <= 1'b0;
                  unique case (state)
                     ST_START1: state <= ST_DEVW;
                     ST_DEVW:   state <= bnack ? ST_STOP : ST_ADDR;
                     ST_ADDR:   state <= bnack ? ST_STOP : ST_START2;
                     ST_START2: state <= ST_DEVR;
                     ST_DEVR:   state <= bnack ? ST_STOP : ST_READ;
                     ST_READ: begin
                        idx   <= idx + 1'b1;
                        state <= (idx == 3'(udcl_pkg::EE_NBYTES - 1)) ? ST_STOP : ST_READ;
                     end
                     default:   state <= ST_APPLY;
                  endcase
                  if (bnack && (state == ST_DEVW || state == ST_ADDR || state == ST_DEVR)) begin
                     failed <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // ==================================================================
   // captured eeprom bytes
   // ==================================================================
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < udcl_pkg::EE_NBYTES; i++) begin
            mem[i] <= '0;
         end
      end else if (state == ST_READ && waiting && bdone) begin
         mem[idx] <= bdata;
      end
   end

   // ==================================================================
   // descriptor outputs
   // ==================================================================
   // held at defaults until the apply step; ready gates host answers
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         desc_o     <= '{udcl_pkg::DEF_VID, udcl_pkg::DEF_PID, udcl_pkg::DEF_ATTR, udcl_pkg::DEF_MAXPWR};
         ready_o    <= 1'b0;
         ee_valid_o <= 1'b0;
      end else if (state == ST_APPLY) begin
         ready_o <= 1'b1;
         if (strap_sda && strap_scl && !failed && mem[udcl_pkg::EE_LOC_SIG] == udcl_pkg::EE_SIGNATURE) begin
            ee_valid_o <= 1'b1;
            desc_o.vid <= {mem[udcl_pkg::EE_LOC_VID_HI], mem[udcl_pkg::EE_LOC_VID_LO]};
            desc_o.pid <= {mem[udcl_pkg::EE_LOC_PID_HI], mem[udcl_pkg::EE_LOC_PID_LO]};
            desc_o.attr <= mem[udcl_pkg::EE_LOC_ATTR];
            // max power in 2 mA units
            desc_o.max_power <= mem[udcl_pkg::EE_LOC_PWR];
         end else begin
            desc_o.vid       <= udcl_pkg::DEF_VID;
            desc_o.pid       <= udcl_pkg::DEF_PID;
            desc_o.attr      <= make_attr(strap_scl, ~strap_sda);
            desc_o.max_power <= udcl_pkg::DEF_MAXPWR;
         end
      end
   end

   // registered copies of the open-drain enables
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         scl_oe_o <= b_scl_oe;
         sda_oe_o <= b_sda_oe;
      end
   end

endmodule // udcl_loader

// ===== rtl/udcl_pkg.sv
package udcl_pkg;

   // ==================================================================
   // clock and i2c timing
   // ==================================================================
   localparam int unsigned CLK_FREQ_HZ     = 250_000_000;
   // fast-mode plus rate: a full eight-byte load stays near 25k clocks
   localparam int unsigned SCL_FREQ_HZ     = 1_000_000;
   // half of one scl period, in system clocks
   localparam int unsigned SCL_HALF_CYC    = CLK_FREQ_HZ / (2 * SCL_FREQ_HZ);
   localparam int unsigned DIV_W           = 11;

   // ==================================================================
   // eeprom layout
   // ==================================================================
   localparam logic [7:0] EE_DEV_WR        = 8'hA0;
   localparam logic [7:0] EE_DEV_RD        = 8'hA1;
   localparam int unsigned EE_NBYTES       = 8;
   localparam logic [2:0] EE_LOC_VID_LO    = 3'h0;
   localparam logic [2:0] EE_LOC_VID_HI    = 3'h1;
   localparam logic [2:0] EE_LOC_PID_LO    = 3'h2;
   localparam logic [2:0] EE_LOC_PID_HI    = 3'h3;
   localparam logic [2:0] EE_LOC_ATTR      = 3'h4;
   localparam logic [2:0] EE_LOC_PWR       = 3'h5;
   localparam logic [2:0] EE_LOC_SIG       = 3'h7;
   // signature value is arbitrary
   localparam logic [7:0] EE_SIGNATURE     = 8'h5A;

   // ==================================================================
   // descriptor defaults
   // ==================================================================
   // identifier defaults are arbitrary
   localparam logic [15:0] DEF_VID         = 16'h1234;
   localparam logic [15:0] DEF_PID         = 16'h0002;
   localparam logic [7:0]  DEF_ATTR        = 8'hA0;
   localparam int unsigned MA_PER_UNIT     = 2;
   localparam int unsigned DEF_POWER_MA    = 94;
   localparam logic [7:0]  DEF_MAXPWR      = 8'(DEF_POWER_MA / MA_PER_UNIT);
   localparam int unsigned ATTR_ONE_BIT    = 7;
   localparam int unsigned ATTR_SELF_BIT   = 6;
   localparam int unsigned ATTR_WAKE_BIT   = 5;

   // ==================================================================
   // carriers
   // ==================================================================
   typedef struct packed {
      logic [15:0] vid;
      logic [15:0] pid;
      logic [7:0]  attr;
      logic [7:0]  max_power;
   } udcl_desc_t;

   typedef enum logic [1:0] {
      UDCL_CMD_START = 2'b00,
      UDCL_CMD_WRITE = 2'b01,
      UDCL_CMD_READ  = 2'b10,
      UDCL_CMD_STOP  = 2'b11
   } udcl_cmd_t;

endpackage

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ==========================================
   // clock, pulls and open drain wires
   // ==========================================
   logic                 clk_i = 1'b0;
   logic                 rst_b_i = 1'b0;
   logic                 scl_pull = 1'b1;
   logic                 sda_pull = 1'b1;
   logic                 ee_on = 1'b1;
   logic [63:0]          ee_mem = 64'h0;
   logic                 ee_oe;
   logic                 scl_oe_o;
   logic                 sda_oe_o;
   logic                 ready_o;
   logic                 ee_valid_o;
   udcl_pkg::udcl_desc_t desc_o;
   int                   bad_count = 0;
   int                   cmp_count = 0;
   int                   cyc = 0;
   always #2 clk_i = ~clk_i;
   // pull resistor sets the strap; any driver wins low
   wire scl_w = scl_pull & ~scl_oe_o;
   wire sda_w = sda_pull & ~sda_oe_o & ~ee_oe;
   udcl_loader DUT (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(scl_oe_o),
      .sda_oe_o(sda_oe_o), .desc_o(desc_o), .ready_o(ready_o), .ee_valid_o(ee_valid_o)
   );
   udcl_ee_model u_ee (.scl_i(scl_w), .sda_i(sda_w), .on_i(ee_on), .mem_i(ee_mem), .sda_oe_o(ee_oe));
   // ==========================================
   // helpers
   // ==========================================
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   function automatic logic [47:0] fb(input logic scl_lv, input logic sda_lv);
      return {udcl_pkg::DEF_VID, udcl_pkg::DEF_PID, 8'h80 | {1'b0, scl_lv, ~sda_lv, 5'h00}, udcl_pkg::DEF_MAXPWR};
   endfunction
   // reset with straps set, defaults seen while held
   task automatic boot(input logic scl_lv, input logic sda_lv);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      scl_pull <= scl_lv;
      sda_pull <= sda_lv;
      repeat (2) @(posedge clk_i);
      #1;
      check(desc_o, {udcl_pkg::DEF_VID, udcl_pkg::DEF_PID, udcl_pkg::DEF_ATTR, udcl_pkg::DEF_MAXPWR});
      check(ready_o, 1'b0);
      @(posedge clk_i);
      rst_b_i <= 1'b1;
   endtask
   task automatic wait_ready(input int lim);
      int n;
      n = 0;
      // look just after each edge so the flag has settled
      while (ready_o !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask
   // ==========================================
   // scenarios
   // ==========================================
   // every strap pair with a low line; straps taken once
   task automatic t_straps();
      logic [1:0] s;
      for (int i = 0; i < 3; i++) begin
         s = 2'(i);
         boot(s[1], s[0]);
         wait_ready(12);
         check(ready_o, 1'b1);
         check({scl_oe_o, sda_oe_o, ee_valid_o}, 3'h0);
         check(desc_o, fb(s[1], s[0]));
         @(posedge clk_i);
         scl_pull <= 1'b1;
         sda_pull <= 1'b1;
         repeat (40) @(posedge clk_i);
         #1;
         check(desc_o, fb(s[1], s[0]));
         check(ee_valid_o, 1'b0);
      end
   endtask
   // both straps high: eeprom read, judged by content
   task automatic t_load(input logic on, input logic [63:0] mem, input logic vld, input logic [47:0] exp);
      @(posedge clk_i);
      ee_on <= on;
      ee_mem <= mem;
      boot(1'b1, 1'b1);
      wait_ready(60000);
      check(ready_o, 1'b1);
      check(ee_valid_o, vld);
      check(desc_o, exp);
   endtask
   // hang guard, a full load needs about 25k cycles, the whole run near 55k
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 80000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // stored attributes keep bit 7 set and bits 4:0 clear
   localparam logic [63:0] GOOD = {udcl_pkg::EE_SIGNATURE, 56'h77_32_E0_13_56_BE_EF};
   initial begin
      t_straps();
      t_load(1'b1, GOOD, 1'b1, {16'hBEEF, 16'h1356, 8'hE0, 8'h32});
      t_load(1'b1, GOOD ^ {8'hFF, 56'h0}, 1'b0, fb(1'b1, 1'b1));
      t_load(1'b0, GOOD, 1'b0, fb(1'b1, 1'b1));
      complete_run();
   end
endmodule // testbench

// ===== sim/udcl_ee_model.sv
`timescale 1ns/1ps
// ==========================================
// behavioural i2c configuration eeprom
// ==========================================
module udcl_ee_model (
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic        on_i,
   input  wire logic [63:0] mem_i,
   output logic             sda_oe_o
);
   logic [7:0] sh = 8'h00;
   logic [7:0] cur = 8'h00;
   logic [2:0] ptr = 3'h0;
   int         cnt = 0;
   logic       act = 1'b0;
   logic       first = 1'b0;
   logic       rd = 1'b0;
   initial sda_oe_o = 1'b0;
   // start or repeated start restarts framing
   always @(negedge sda_i) begin
      if (scl_i) begin
         act = 1'b1;
         cnt = 0;
         first = 1'b1;
         rd = 1'b0;
      end
   end
   // stop ends the transfer
   always @(posedge sda_i) begin
      if (scl_i) begin
         act = 1'b0;
      end
   end
   // bits in on scl rise; master nack ends a read
   always @(posedge scl_i) begin
      if (act) begin
         if (cnt < 8) begin
            sh = {sh[6:0], sda_i};
         end else if (rd && sda_i) begin
            act = 1'b0;
         end
         cnt = cnt + 1;
      end
   end
   // drive only while scl is low, so no false start
   always @(negedge scl_i) begin
      if (act && cnt == 8 && !rd) begin
         if (first && (sh[7:1] != 7'h50 || !on_i)) begin
            act = 1'b0;
         end else if (first) begin
            sda_oe_o <= 1'b1;
            rd = sh[0];
         end else begin
            sda_oe_o <= 1'b1;
            ptr = sh[2:0];
         end
         first = 1'b0;
      end else if (act && cnt == 8) begin
         sda_oe_o <= 1'b0;
         ptr = ptr + 3'h1;
      end else if (act && cnt == 9) begin
         cnt = 0;
         cur = mem_i[8*ptr+:8];
         sda_oe_o <= rd & ~cur[7];
      end else if (act && rd && cnt > 0 && cnt < 8) begin
         sda_oe_o <= ~cur[7-cnt];
      end
   end
endmodule // udcl_ee_model

// ===== sim/udcl_loader_props.sv
`timescale 1ns/1ps
// ==========================================
// descriptor loader checker
// ==========================================
module udcl_loader_props (
   input wire logic                 clk_i,
   input wire logic                 rst_b_i,
   input wire logic                 scl_i,
   input wire logic                 sda_i,
   input wire logic                 scl_oe_o,
   input wire logic                 sda_oe_o,
   input wire udcl_pkg::udcl_desc_t desc_o,
   input wire logic                 ready_o,
   input wire logic                 ee_valid_o
);
   logic bus_used;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // sticky: loader touched the bus since reset
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bus_used <= 1'b0;
      end else if (scl_oe_o || sda_oe_o) begin
         bus_used <= 1'b1;
      end
   end
   property p_ready_holds; ready_o |=> ready_o; endproperty
   a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
   property p_frozen; ready_o |=> $stable(desc_o) && $stable(ee_valid_o); endproperty
   a_frozen: assert property (p_frozen) else $error("descriptor changed after ready");
   property p_bus_free; ready_o |-> !scl_oe_o && !sda_oe_o; endproperty
   a_bus_free: assert property (p_bus_free) else $error("bus held after ready");
   property p_fb_ids;
      ready_o && !ee_valid_o |-> desc_o.vid == udcl_pkg::DEF_VID && desc_o.pid == udcl_pkg::DEF_PID
         && desc_o.max_power == udcl_pkg::DEF_MAXPWR;
   endproperty
   a_fb_ids: assert property (p_fb_ids) else $error("fallback ids or power wrong");
   property p_fb_form; ready_o && !ee_valid_o |-> desc_o.attr[7] && desc_o.attr[4:0] == 5'h00; endproperty
   a_fb_form: assert property (p_fb_form) else $error("fallback attribute form wrong");
   property p_no_probe; ready_o && !ee_valid_o && desc_o.attr[6:5] != 2'b10 |-> !bus_used; endproperty
   a_no_probe: assert property (p_no_probe) else $error("probe with a low strap");
   property p_strap_attr; $rose(ready_o) && !bus_used |-> desc_o.attr[6:5] == {scl_i, !sda_i}; endproperty
   a_strap_attr: assert property (p_strap_attr) else $error("strap bits wrong");
   property p_valid_loaded; ee_valid_o |-> bus_used; endproperty
   a_valid_loaded: assert property (p_valid_loaded) else $error("valid without a read");
   property p_quick; $rose(rst_b_i) && !(scl_i && sda_i) |-> ##[1:8] ready_o; endproperty
   a_quick: assert property (p_quick) else $error("strap only ready late");
   // main scenarios
   c_loaded: cover property ($rose(ee_valid_o));
   c_strap_only: cover property ($rose(ready_o) && !bus_used);
   c_fallback_bus: cover property ($rose(ready_o) && bus_used && !ee_valid_o);
endmodule // udcl_loader_props

bind udcl_loader udcl_loader_props u_props (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .scl_oe_o(scl_oe_o),
   .sda_oe_o(sda_oe_o), .desc_o(desc_o), .ready_o(ready_o), .ee_valid_o(ee_valid_o)
);
